/* File: rba_pkg.sv */
// shared constants, access-type codes and strobe carrier for the register bit cells
package rba_pkg;
    localparam int RBA_WIDTH = 16;
    localparam int RBA_TYPE_W = 4;

    typedef enum logic [3:0] {
        RBA_RW                  = 4'h0,
        RBA_RO                  = 4'h1,
        RBA_WO                  = 4'h2,
        RBA_W1S                 = 4'h3,
        RBA_W1C                 = 4'h4,
        RBA_WRITE_ANY_CLEAR     = 4'h5,
        RBA_RC                  = 4'h6,
        RBA_READONLY_LATCH_HIGH = 4'h7,
        RBA_LATCH_LOW_ON_READ   = 4'h8,
        RBA_SELF_CLEARING       = 4'h9
    } rba_access_e;

    // one nibble per bit, bit 0 in the low nibble
    localparam logic [RBA_WIDTH*RBA_TYPE_W-1:0] RBA_DEFAULT_TYPES = 64'h0000_0098_7654_3210;
    // the latch-low cell starts high so a first low is seen
    localparam logic [RBA_WIDTH-1:0] RBA_DEFAULT_RESET = 16'h0100;
    localparam logic RBA_READ_ZERO = 1'h0;

    typedef struct packed {
        logic wr;
        logic rd;
    } rba_access_s;
endpackage

/* File: rba_bank.sv */
// register bank whose bits each follow one access attribute
`timescale 1ns/1ps
// Overview of operation
// - a readable bit returns its stored value whenever the register is read.
// - a writable bit takes the data written to it.
// - a read-only bit ignores every write and shows the hardware value.
// - a write-only bit accepts writes and its read-back data is unspecified (reads here give zero).
// - a write-one-to-set bit becomes one on a written one and is unchanged by a written zero.
// - a write-one-to-clear bit becomes zero on a written one unless its hardware event sets it in the same cycle, and is unchanged by a written zero.
// - a write-anything-to-clear bit becomes zero on any write unless its hardware event sets it in the same cycle.
// - a read-to-clear bit returns its value, then becomes zero unless its hardware event sets it in the same cycle, and ignores writes.
// - a latch-high bit stays one until read, then follows its cause.
// - a latch-low bit holds a low until read, and the read releases it.
// - a self-clearing bit returns to zero by itself after a write of one; writing zero does nothing.
module rba_bank
    import rba_pkg::*;
#(
    parameter int                          WIDTH       = RBA_WIDTH,
    parameter logic [WIDTH*RBA_TYPE_W-1:0] BIT_TYPES   = RBA_DEFAULT_TYPES,
    parameter logic [WIDTH-1:0]            RESET_VALUE = RBA_DEFAULT_RESET
) (
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire rba_access_s       access_in,
    input  wire logic [WIDTH-1:0]  wr_data_in,
    input  wire logic [WIDTH-1:0]  hw_in,
    output logic      [WIDTH-1:0]  rd_data_out,
    output logic                   rd_valid_out,
    output logic      [WIDTH-1:0]  bits_out
);

    // next stored value of one cell
    function automatic logic rba_next_bit(
        input rba_access_e t,
        input logic        cur,
        input logic        wr,
        input logic        wd,
        input logic        rd,
        input logic        hw
    );
        logic n;
        case (t)
            RBA_RW, RBA_WO: n = wr ? wd : cur;
            RBA_RO:         n = hw;
            RBA_W1S:        n = cur | (wr & wd);
            RBA_W1C:        n = hw | (cur & ~(wr & wd));
            RBA_WRITE_ANY_CLEAR:             n = hw | (cur & ~wr);
            RBA_RC, RBA_READONLY_LATCH_HIGH: n = hw | (cur & ~rd);
            RBA_LATCH_LOW_ON_READ:           n = hw & (cur | rd);
            RBA_SELF_CLEARING:               n = wr & wd;
            default:        n = cur;
        endcase
        return n;
    endfunction

    // value a cell presents on a read
    function automatic logic rba_read_bit(input rba_access_e t, input logic cur);
        logic r;
        case (t)
            RBA_WO:  r = RBA_READ_ZERO;
            default: r = cur;
        endcase
        return r;
    endfunction

    logic [WIDTH-1:0] bits_reg;
    logic [WIDTH-1:0] bits_next;
    logic [WIDTH-1:0] read_view;
    logic [WIDTH-1:0] rd_data_reg;
    logic             rd_valid_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            localparam rba_access_e T = rba_access_e'(BIT_TYPES[i*RBA_TYPE_W +: RBA_TYPE_W]);
            assign bits_next[i] = rba_next_bit(T, bits_reg[i], access_in.wr, wr_data_in[i],
                                               access_in.rd, hw_in[i]);
            assign read_view[i] = rba_read_bit(T, bits_reg[i]);

            if (T != RBA_WO) begin : g_readable
                property p_read_value;
                    @(posedge clock_in) disable iff (rst_in)
                    access_in.rd |=> rd_valid_out && (rd_data_out[i] == $past(bits_reg[i]));
                endproperty
                a_read_value: assert property (p_read_value) else $error("read data mismatch");
            end
            if (T == RBA_RW) begin : g_rw
                property p_rw_write;
                    @(posedge clock_in) disable iff (rst_in)
                    access_in.wr |=> bits_out[i] == $past(wr_data_in[i]);
                endproperty
                a_rw_write: assert property (p_rw_write) else $error("rw bit did not take write");
            end
            if (T == RBA_RO) begin : g_ro
                property p_ro_follow;
                    @(posedge clock_in) disable iff (rst_in)
                    access_in.wr |=> bits_out[i] == $past(hw_in[i]);
                endproperty
                a_ro_follow: assert property (p_ro_follow) else $error("ro bit changed by write");
            end
            if (T == RBA_WO) begin : g_wo
                property p_wo_write;
                    @(posedge clock_in) disable iff (rst_in)
                    access_in.wr |=> bits_out[i] == $past(wr_data_in[i]);
                endproperty
                a_wo_write: assert property (p_wo_write) else $error("wo bit did not take write");
            end
            if (T == RBA_W1S) begin : g_w1s
                property p_w1s;
                    @(posedge clock_in) disable iff (rst_in)
                    (access_in.wr && wr_data_in[i]) |=> bits_out[i];
                endproperty
                property p_w1s_zero;
                    @(posedge clock_in) disable iff (rst_in)
                    !(access_in.wr && wr_data_in[i]) |=> $stable(bits_out[i]);
                endproperty
                a_w1s: assert property (p_w1s) else $error("w1s bit not set");
                a_w1s_zero: assert property (p_w1s_zero) else $error("w1s bit changed");
            end
            if (T == RBA_W1C) begin : g_w1c
                property p_w1c;
                    @(posedge clock_in) disable iff (rst_in)
                    (access_in.wr && wr_data_in[i] && !hw_in[i]) |=> !bits_out[i];
                endproperty
                property p_w1c_set;
                    @(posedge clock_in) disable iff (rst_in)
                    hw_in[i] |=> bits_out[i];
                endproperty
                property p_w1c_zero;
                    @(posedge clock_in) disable iff (rst_in)
                    !(access_in.wr && wr_data_in[i]) && !hw_in[i] |=> $stable(bits_out[i]);
                endproperty
                a_w1c: assert property (p_w1c) else $error("w1c bit not cleared");
                a_w1c_set: assert property (p_w1c_set) else $error("w1c set event lost");
                a_w1c_zero: assert property (p_w1c_zero) else $error("w1c bit changed by zero");
            end
            if (T == RBA_WRITE_ANY_CLEAR) begin : g_wr_any_clear
                property p_wr_any_clear;
                    @(posedge clock_in) disable iff (rst_in)
                    (access_in.wr && !hw_in[i]) |=> !bits_out[i];
                endproperty
                property p_wr_any_set;
                    @(posedge clock_in) disable iff (rst_in)
                    hw_in[i] |=> bits_out[i];
                endproperty
                a_wr_any_clear: assert property (p_wr_any_clear) else $error("write clear failed");
                a_wr_any_set: assert property (p_wr_any_set) else $error("write clear set lost");
            end
            if (T == RBA_RC) begin : g_rc
                sequence s_rc_read;
                    access_in.rd && bits_reg[i] && !hw_in[i];
                endsequence
                property p_rc;
                    @(posedge clock_in) disable iff (rst_in)
                    s_rc_read |=> rd_data_out[i] && !bits_out[i];
                endproperty
                property p_rc_set;
                    @(posedge clock_in) disable iff (rst_in)
                    (access_in.rd && hw_in[i]) |=> bits_out[i];
                endproperty
                a_rc: assert property (p_rc) else $error("rc bit not cleared by read");
                a_rc_set: assert property (p_rc_set) else $error("rc set lost to read");
            end
            if (T == RBA_READONLY_LATCH_HIGH) begin : g_lat_hi
                property p_lat_hi_hold;
                    @(posedge clock_in) disable iff (rst_in)
                    (bits_reg[i] && !access_in.rd) |=> bits_out[i];
                endproperty
                property p_lat_hi_after;
                    @(posedge clock_in) disable iff (rst_in)
                    access_in.rd |=> bits_out[i] == $past(hw_in[i]);
                endproperty
                property p_lat_hi_set;
                    @(posedge clock_in) disable iff (rst_in)
                    hw_in[i] |=> bits_out[i];
                endproperty
                a_lat_hi_hold: assert property (p_lat_hi_hold) else $error("latch high dropped early");
                a_lat_hi_after: assert property (p_lat_hi_after) else $error("latch high read wrong");
                a_lat_hi_set: assert property (p_lat_hi_set) else $error("latch high not set");
            end
            if (T == RBA_LATCH_LOW_ON_READ) begin : g_lat_lo
                property p_lat_lo_hold;
                    @(posedge clock_in) disable iff (rst_in)
                    (!bits_reg[i] && !access_in.rd) |=> !bits_out[i];
                endproperty
                property p_lat_lo_release;
                    @(posedge clock_in) disable iff (rst_in)
                    access_in.rd |=> bits_out[i] == $past(hw_in[i]);
                endproperty
                property p_lat_lo_capture;
                    @(posedge clock_in) disable iff (rst_in)
                    !hw_in[i] |=> !bits_out[i];
                endproperty
                a_lat_lo_hold: assert property (p_lat_lo_hold) else $error("latch low lost");
                a_lat_lo_release: assert property (p_lat_lo_release) else $error("latch low release wrong");
                a_lat_lo_capture: assert property (p_lat_lo_capture) else $error("latch low missed");
            end
            if (T == RBA_SELF_CLEARING) begin : g_self_clear
                sequence s_self_clear_set;
                    access_in.wr && wr_data_in[i];
                endsequence
                sequence s_self_clear_pulse;
                    bits_out[i] ##1 !bits_out[i];
                endsequence
                // a one written in back-to-back cycles keeps the bit up, so the pulse is judged after the last one
                property p_self_clear;
                    @(posedge clock_in) disable iff (rst_in)
                    s_self_clear_set ##1 !(access_in.wr && wr_data_in[i]) |-> s_self_clear_pulse;
                endproperty
                property p_self_clear_zero;
                    @(posedge clock_in) disable iff (rst_in)
                    !(access_in.wr && wr_data_in[i]) |=> !bits_out[i];
                endproperty
                a_self_clear: assert property (p_self_clear) else $error("self clearing pulse wrong");
                a_self_clear_zero: assert property (p_self_clear_zero) else $error("stray self set");
            end
        end
    endgenerate

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            bits_reg     <= RESET_VALUE;
            rd_data_reg  <= '0;
            rd_valid_reg <= 1'b0;
        end else begin
            bits_reg     <= bits_next;
            rd_valid_reg <= access_in.rd;
            if (access_in.rd) begin
                rd_data_reg <= read_view;
            end
        end
    end

    property p_rd_valid_pulse;
        @(posedge clock_in) disable iff (rst_in)
        !access_in.rd |=> !rd_valid_out;
    endproperty
    property p_rd_data_hold;
        @(posedge clock_in) disable iff (rst_in)
        !access_in.rd |=> $stable(rd_data_out);
    endproperty
    a_rd_valid_pulse: assert property (p_rd_valid_pulse) else $error("read valid without read");
    a_rd_data_hold: assert property (p_rd_data_hold) else $error("read data changed without read");

    assign rd_data_out  = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
    assign bits_out     = bits_reg;

endmodule

/* File: register_bit_access_types_tb.sv */
// self-checking testbench for the register bit access bank
`timescale 1ns/1ps
module register_bit_access_types_tb;
    import rba_pkg::*;

    logic                 clock_in;
    logic                 rst_in;
    rba_access_s          access_in;
    logic [RBA_WIDTH-1:0] wr_data_in;
    logic [RBA_WIDTH-1:0] hw_in;
    logic [RBA_WIDTH-1:0] rd_data_out;
    logic                 rd_valid_out;
    logic [RBA_WIDTH-1:0] bits_out;
    int                   bad_count;
    int                   checked;

    // latch-low cause held high unless a scenario drops it
    localparam logic [RBA_WIDTH-1:0] HW_IDLE = 16'h0100;
    // write-only bit read-back is unspecified, so it is masked
    localparam logic [RBA_WIDTH-1:0] RD_MASK = 16'hFFFB;

    rba_bank u_dut (
        .clock_in     (clock_in),
        .rst_in       (rst_in),
        .access_in    (access_in),
        .wr_data_in   (wr_data_in),
        .hw_in        (hw_in),
        .rd_data_out  (rd_data_out),
        .rd_valid_out (rd_valid_out),
        .bits_out     (bits_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    task automatic chk(input string name, input logic [RBA_WIDTH-1:0] exp, input logic [RBA_WIDTH-1:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // an idle edge with the hardware inputs held, then one access cycle, then the check
    task automatic step(input logic w, input logic r, input logic [RBA_WIDTH-1:0] wd,
                        input logic [RBA_WIDTH-1:0] hw, input logic [RBA_WIDTH-1:0] eb,
                        input logic [RBA_WIDTH-1:0] er);
        @(posedge clock_in);
        access_in  <= '{wr: w, rd: r};
        wr_data_in <= wd;
        hw_in      <= hw;
        @(posedge clock_in);
        access_in  <= '{wr: 1'b0, rd: 1'b0};
        #1;
        chk("bits_out", eb, bits_out);
        chk("rd_valid_out", {15'h0000, r}, {15'h0000, rd_valid_out});
        if (r) begin
            chk("rd_data_out", er & RD_MASK, rd_data_out & RD_MASK);
        end
    endtask

    task automatic scen_write_paths();
        // all ones: writable, set and self-clearing bits rise, protected bits hold
        step(1'b1, 1'b0, 16'hFFFF, HW_IDLE, 16'hFF0D, 16'h0000);
        step(1'b0, 1'b0, 16'h0000, HW_IDLE, 16'hFD0D, 16'h0000);
        // all zeros: set bit stays, self-clearing bit stays low
        step(1'b1, 1'b0, 16'h0000, HW_IDLE, 16'h0108, 16'h0000);
    endtask

    task automatic scen_hw_events();
        // hardware events set the status bits and drive the read-only bit
        step(1'b0, 1'b0, 16'h0000, 16'h01F2, 16'h01FA, 16'h0000);
        // cause removed: latch-high holds until read
        step(1'b0, 1'b0, 16'h0000, HW_IDLE, 16'h01F8, 16'h0000);
        // read returns the value, then read-clear and released latch-high fall
        step(1'b0, 1'b1, 16'h0000, HW_IDLE, 16'h0138, 16'h01F8);
    endtask

    task automatic scen_write_clears();
        // zero written: clear-on-one holds, clear-on-any falls
        step(1'b1, 1'b0, 16'h0000, HW_IDLE, 16'h0118, 16'h0000);
        step(1'b1, 1'b0, 16'h0010, HW_IDLE, 16'h0108, 16'h0000);
    endtask

    task automatic scen_priority();
        // set events beat a write clear and a read clear in the same cycle
        step(1'b1, 1'b1, 16'h0030, 16'h01F0, 16'h01F8, 16'h0108);
        step(1'b1, 1'b0, 16'h0000, HW_IDLE, 16'h01D8, 16'h0000);
    endtask

    task automatic scen_latch_low();
        // latch-low captures a low and holds it until the read releases it
        step(1'b0, 1'b0, 16'h0000, 16'h0000, 16'h00D8, 16'h0000);
        step(1'b0, 1'b0, 16'h0000, HW_IDLE, 16'h00D8, 16'h0000);
        step(1'b0, 1'b1, 16'h0000, HW_IDLE, 16'h0118, 16'h00D8);
        step(1'b0, 1'b0, 16'h0000, HW_IDLE, 16'h0118, 16'h0000);
        // a low arriving with the read is captured, not released
        step(1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0018, 16'h0118);
    endtask

    task automatic scen_reset();
        // mid-run reset returns every cell and the read port to the reset state
        @(posedge clock_in);
        rst_in <= 1'b1;
        hw_in  <= HW_IDLE;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
        chk("reset bits_out", RBA_DEFAULT_RESET, bits_out);
        chk("reset rd_data_out", 16'h0000, rd_data_out);
        chk("reset rd_valid_out", 16'h0000, {15'h0000, rd_valid_out});
        step(1'b0, 1'b1, 16'h0000, HW_IDLE, 16'h0100, 16'h0100);
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        bad_count  = 0;
        checked    = 0;
        rst_in     = 1'b1;
        access_in  = '{wr: 1'b0, rd: 1'b0};
        wr_data_in = 16'h0000;
        hw_in      = HW_IDLE;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
        chk("reset bits_out", RBA_DEFAULT_RESET, bits_out);
        chk("reset rd_data_out", 16'h0000, rd_data_out);
        scen_write_paths();
        scen_hw_events();
        scen_write_clears();
        scen_priority();
        scen_latch_low();
        scen_reset();
        give_verdict();
    end
endmodule
